/* rtl/rts_defines.svh */
// named constants of the reset time-out sequencer
// assumes inclusion by bare name from the package and the top module
`ifndef RTS_DEFINES_SVH
`define RTS_DEFINES_SVH

// ==========================================================
// clock and timing
`define RTS_CLK_MHZ 250
`define RTS_PLL_LOCK_US 2000
`define RTS_OST_CYCLES 1024
`define RTS_POWERUP_DELAY_TIMER_RC_TICKS 72
`define RTS_BOR_MIN_NS 100

// ==========================================================
// register map, byte addresses
`define RTS_ADR_W 8
`define RTS_ADR_CTRL 8'h00
`define RTS_ADR_STATUS 8'h04
`define RTS_CTRL_RST 5'h0B

// ==========================================================
// synchroniser lanes
`define RTS_SYN_W 5
`define RTS_SYN_POR 0
`define RTS_SYN_LOW 1
`define RTS_SYN_MASTER_CLEAR_N 2
`define RTS_SYN_OSC 3
`define RTS_SYN_RC 4
`define RTS_SYN_RST 5'h00

`endif

/* rtl/rts_pkg.sv */
// types of the reset time-out sequencer
// assumes rts_defines.svh is on the include path
`include "rts_defines.svh"

package rts_pkg;

    // ==========================================================
    // sequencer states, one-hot
    typedef enum logic [5:0] {
        RTS_ST_IDLE = 6'h01,
        RTS_ST_BOR = 6'h02,
        RTS_ST_POWERUP_DELAY_TIMER = 6'h04,
        RTS_ST_OST = 6'h08,
        RTS_ST_PLL = 6'h10,
        RTS_ST_RUN = 6'h20
    } rts_state_e;

    // ==========================================================
    // oscillator modes
    typedef enum logic [1:0] {
        RTS_OSC_RC = 2'h0,
        RTS_OSC_LP = 2'h1,
        RTS_OSC_XT = 2'h2,
        RTS_OSC_HS = 2'h3
    } rts_osc_mode_e;

    // ==========================================================
    // control register, low bits first at the bottom
    typedef struct packed {
        logic pll_en;
        rts_osc_mode_e osc_mode;
        logic brownout_enable_cfg;
        logic powerup_delay_timer_en;
    } rts_ctrl_s;

    typedef struct packed {
        logic por_origin;
        logic brownout_active;
        logic core_reset;
        rts_state_e state;
    } rts_status_s;

endpackage : rts_pkg

/* rtl/rts_sync.sv */
// bank of two-flop synchronisers, one per lane
// assumes inputs asynchronous to clk; first stage read only by second
`timescale 1ns/1ps

module rts_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // ==========================================================
    // per-lane flops
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_lane
            logic meta_ff;
            logic sync_ff;
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_ff <= RST_VAL[i];
                    sync_ff <= RST_VAL[i];
                end else if (ce) begin
                    meta_ff <= d[i];
                    sync_ff <= meta_ff;
                end
            end
            assign q[i] = sync_ff;
        end
    endgenerate

endmodule : rts_sync

/* rtl/rts_sequencer.sv */
// reset time-out sequencer: power-up delay, oscillator start-up, pll lock
// assumes pins and detector levels asynchronous, wishbone master on clk
`timescale 1ns/1ps
`include "rts_defines.svh"

// Contract
// RQ1: a power-on pulse from the detector starts the time-out chain.
// RQ2: power-up delay runs after power-on and holds reset while counting.
// RQ3: a control bit enables the power-up delay; disabled means skipped.
// RQ4: the power-up delay counts internal rc oscillator ticks only.
// RQ5: oscillator start-up counts 1024 external oscillator cycles after power-up delay.
// RQ6: start-up count only in crystal modes, only on power-on or wake.
// RQ7: with pll enabled, a 2 ms lock delay follows the start-up count; code runs it after power-on only, not after wake.
// RQ8: brown-out enable bit clear disables brown-out reset, set enables it.
// RQ9: brown-out trips only after supply stays low a minimum time.
// RQ10: brown-out reset holds until the supply returns above threshold.
// RQ11: on recovery, an enabled power-up delay extends reset by full length.
// RQ12: supply low during that delay re-enters brown-out, timer reinitialised.
// RQ13: on power-up, power-up delay runs first, then oscillator start-up.
// RQ14: rc mode with power-up delay off leaves reset without delay; code still runs the pll lock delay there when pll is enabled.
// RQ15: chain ignores master clear; late release starts execution at once.
// RQ16: power-up delay length and brown-out minimum are parameters.
// RQ17: reset out while master clear low, brown-out, or any stage counting.
module rts_sequencer
    import rts_pkg::*;
#(
    parameter int POWERUP_DELAY_TIMER_RC_TICKS = `RTS_POWERUP_DELAY_TIMER_RC_TICKS,
    parameter int OST_CYCLES = `RTS_OST_CYCLES,
    parameter int PLL_LOCK_CYCLES = `RTS_PLL_LOCK_US * `RTS_CLK_MHZ,
    parameter int BOR_MIN_CYCLES = (`RTS_BOR_MIN_NS * `RTS_CLK_MHZ + 999) / 1000,
    parameter int CNT_W = 20,
    parameter int BOR_W = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic por_detect,
    input wire logic supply_low,
    input wire logic master_clear_n,
    input wire logic ext_osc_in,
    input wire logic rc_osc_in,
    input wire logic wake_req,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`RTS_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic core_reset,
    output logic brownout_active
);

    // ==========================================================
    // input synchronisers
    logic [`RTS_SYN_W-1:0] syn_d;
    logic [`RTS_SYN_W-1:0] syn_q;

    assign syn_d[`RTS_SYN_POR] = por_detect;
    assign syn_d[`RTS_SYN_LOW] = supply_low;
    assign syn_d[`RTS_SYN_MASTER_CLEAR_N] = master_clear_n;
    assign syn_d[`RTS_SYN_OSC] = ext_osc_in;
    assign syn_d[`RTS_SYN_RC] = rc_osc_in;

    rts_sync #(
        .W(`RTS_SYN_W),
        .RST_VAL(`RTS_SYN_RST)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d(syn_d),
        .q(syn_q)
    );

    logic por_s;
    logic low_s;
    logic master_clear_n_n_s;
    logic osc_s;
    logic rc_s;

    assign por_s = syn_q[`RTS_SYN_POR];
    assign low_s = syn_q[`RTS_SYN_LOW];
    assign master_clear_n_n_s = syn_q[`RTS_SYN_MASTER_CLEAR_N];
    assign osc_s = syn_q[`RTS_SYN_OSC];
    assign rc_s = syn_q[`RTS_SYN_RC];

    // ==========================================================
    // edge detection on synchronised levels
    logic por_prev_ff;
    logic osc_prev_ff;
    logic rc_prev_ff;
    logic por_rise;
    logic osc_edge;
    logic rc_tick;

    assign por_rise = por_s & ~por_prev_ff;
    assign osc_edge = osc_s & ~osc_prev_ff;
    assign rc_tick = rc_s & ~rc_prev_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            por_prev_ff <= 1'b0;
            osc_prev_ff <= 1'b0;
            rc_prev_ff <= 1'b0;
        end else if (ce) begin
            por_prev_ff <= por_s;
            osc_prev_ff <= osc_s;
            rc_prev_ff <= rc_s;
        end
    end

    // ==========================================================
    // wishbone slave and control register
    rts_ctrl_s ctrl_ff;
    rts_ctrl_s nxt_ctrl;
    logic ack_ff;
    logic nxt_ack;
    logic [31:0] dat_ff;
    logic [31:0] nxt_dat;
    rts_status_s status;
    logic wb_req;

    assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_ack = wb_req;
        nxt_dat = 32'h00000000;
        if (wb_req) begin
            case (wb_adr_i)
                `RTS_ADR_CTRL: begin
                    // RQ3 RQ8 config write
                    if (wb_we_i && wb_sel_i[0]) begin
                        nxt_ctrl = rts_ctrl_s'(wb_dat_i[$bits(rts_ctrl_s)-1:0]);
                    end
                    nxt_dat = 32'(ctrl_ff);
                end
                `RTS_ADR_STATUS: begin
                    nxt_dat = 32'(status);
                end
                default: begin
                    nxt_dat = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= rts_ctrl_s'(`RTS_CTRL_RST);
            ack_ff <= 1'b0;
            dat_ff <= 32'h00000000;
        end else if (ce) begin
            ctrl_ff <= nxt_ctrl;
            ack_ff <= nxt_ack;
            dat_ff <= nxt_dat;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    // ==========================================================
    // brown-out qualification
    logic [BOR_W-1:0] bor_cnt_ff;
    logic [BOR_W-1:0] nxt_bor_cnt;
    logic bor_trip;

    always_comb begin
        nxt_bor_cnt = bor_cnt_ff;
        if (!low_s) begin
            nxt_bor_cnt = '0;
        end else if (bor_cnt_ff != BOR_W'(BOR_MIN_CYCLES)) begin
            nxt_bor_cnt = bor_cnt_ff + BOR_W'(1);
        end
    end

    // RQ8 RQ9 RQ16 qualified trip
    assign bor_trip = ctrl_ff.brownout_enable_cfg & low_s
        & (bor_cnt_ff == BOR_W'(BOR_MIN_CYCLES));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bor_cnt_ff <= '0;
        end else if (ce) begin
            bor_cnt_ff <= nxt_bor_cnt;
        end
    end

    // ==========================================================
    // time-out chain
    rts_state_e state_ff;
    rts_state_e nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic por_origin_ff;
    logic nxt_por_origin;
    logic core_reset_ff;
    logic nxt_core_reset;
    logic bor_act_ff;
    logic nxt_bor_act;
    logic xtal;

    assign xtal = ctrl_ff.osc_mode != RTS_OSC_RC;

    // RQ6 RQ7 stage after start-up count
    function automatic rts_state_e after_ost(input logic por_org, input logic pll);
        if (por_org && pll) begin
            return RTS_ST_PLL;
        end
        return RTS_ST_RUN;
    endfunction : after_ost

    // RQ6 RQ13 stage after power-up delay
    function automatic rts_state_e after_powerup_delay_timer(input logic por_org, input logic xt,
                                              input logic pll);
        if (por_org && xt) begin
            return RTS_ST_OST;
        end
        return after_ost(por_org, pll);
    endfunction : after_powerup_delay_timer

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_por_origin = por_origin_ff;
        if (por_rise) begin
            // RQ1 RQ13 RQ14 chain start
            nxt_por_origin = 1'b1;
            nxt_cnt = '0;
            if (ctrl_ff.powerup_delay_timer_en) begin
                nxt_state = RTS_ST_POWERUP_DELAY_TIMER;
            end else begin
                nxt_state = after_powerup_delay_timer(1'b1, xtal, ctrl_ff.pll_en);
            end
        end else if (bor_trip || (state_ff == RTS_ST_POWERUP_DELAY_TIMER && !por_origin_ff
                                  && low_s && ctrl_ff.brownout_enable_cfg)) begin
            // RQ12 re-enter brown-out
            nxt_state = RTS_ST_BOR;
            nxt_cnt = '0;
            nxt_por_origin = 1'b0;
        end else begin
            case (state_ff)
                RTS_ST_IDLE: begin
                    nxt_state = RTS_ST_IDLE;
                end
                RTS_ST_BOR: begin
                    // RQ10 RQ11 hold until recovered
                    if (!low_s) begin
                        nxt_cnt = '0;
                        nxt_state = ctrl_ff.powerup_delay_timer_en ? RTS_ST_POWERUP_DELAY_TIMER : RTS_ST_RUN;
                    end
                end
                RTS_ST_POWERUP_DELAY_TIMER: begin
                    // RQ2 RQ4 RQ16 rc tick count
                    if (rc_tick) begin
                        if (cnt_ff == CNT_W'(POWERUP_DELAY_TIMER_RC_TICKS - 1)) begin
                            nxt_cnt = '0;
                            nxt_state = after_powerup_delay_timer(por_origin_ff, xtal, ctrl_ff.pll_en);
                        end else begin
                            nxt_cnt = cnt_ff + CNT_W'(1);
                        end
                    end
                end
                RTS_ST_OST: begin
                    // RQ5 oscillator edge count
                    if (osc_edge) begin
                        if (cnt_ff == CNT_W'(OST_CYCLES - 1)) begin
                            nxt_cnt = '0;
                            nxt_state = after_ost(por_origin_ff, ctrl_ff.pll_en);
                        end else begin
                            nxt_cnt = cnt_ff + CNT_W'(1);
                        end
                    end
                end
                RTS_ST_PLL: begin
                    // RQ7 lock delay
                    if (cnt_ff == CNT_W'(PLL_LOCK_CYCLES - 1)) begin
                        nxt_cnt = '0;
                        nxt_state = RTS_ST_RUN;
                    end else begin
                        nxt_cnt = cnt_ff + CNT_W'(1);
                    end
                end
                RTS_ST_RUN: begin
                    // RQ6 wake restarts start-up count
                    if (wake_req && xtal) begin
                        nxt_cnt = '0;
                        nxt_por_origin = 1'b0;
                        nxt_state = RTS_ST_OST;
                    end
                end
                default: begin
                    nxt_state = RTS_ST_IDLE;
                    nxt_cnt = '0;
                end
            endcase
        end
        // RQ15 RQ17 reset output
        nxt_core_reset = ~master_clear_n_n_s | (nxt_state != RTS_ST_RUN);
        nxt_bor_act = nxt_state == RTS_ST_BOR;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= RTS_ST_IDLE;
            cnt_ff <= '0;
            por_origin_ff <= 1'b0;
            core_reset_ff <= 1'b1;
            bor_act_ff <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            por_origin_ff <= nxt_por_origin;
            core_reset_ff <= nxt_core_reset;
            bor_act_ff <= nxt_bor_act;
        end
    end

    assign core_reset = core_reset_ff;
    assign brownout_active = bor_act_ff;

    assign status.por_origin = por_origin_ff;
    assign status.brownout_active = bor_act_ff;
    assign status.core_reset = core_reset_ff;
    assign status.state = state_ff;

endmodule : rts_sequencer

/* tb/rts_sequencer_properties.sv */
// concurrent checks on the sequencer ports
// assumes a bind from the bench top and one clock domain
`timescale 1ns/1ps
module rts_sequencer_properties #(
    parameter int BOR_MIN_CYCLES = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic supply_low,
    input wire logic master_clear_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic core_reset,
    input wire logic brownout_active
);
    // ==============================
    // run length of a low supply
    int low_cnt_ff;
    int nxt_low_cnt;
    always_comb nxt_low_cnt = supply_low ? low_cnt_ff + 1 : 0;
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            low_cnt_ff <= 0;
        else if (ce)
            low_cnt_ff <= nxt_low_cnt;
    end
    // ==============================
    // assertions
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_ack_single: assert property (wb_ack_o && ce |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
        else $error("no ack one cycle after request");
    chk_master_clear_n_holds: assert property ((!master_clear_n && ce) [*4] |-> core_reset)
        else $error("core reset low while master clear held");
    chk_bor_holds: assert property (brownout_active |-> core_reset)
        else $error("core reset low during brownout");
    chk_bor_min: assert property ($rose(brownout_active) && !$past(core_reset) |->
        low_cnt_ff >= BOR_MIN_CYCLES)
        else $error("brownout entered on a short dip");
    chk_bor_stays: assert property ((supply_low && brownout_active && ce) [*3]
        |=> brownout_active)
        else $error("brownout left while supply low");
    // delay after recovery, delay enabled in bench
    chk_bor_recover: assert property ($fell(brownout_active) |-> core_reset [*8])
        else $error("no power-up delay after brownout");
    chk_release_master_clear_n: assert property ($fell(core_reset) |->
        $past(master_clear_n, 2) && !brownout_active)
        else $error("core reset released with pin low or brownout");
endmodule : rts_sequencer_properties

/* tb/rts_far_end.sv */
// far-end model: crystal and internal oscillator sources
// assumes periods unrelated to the 4 ns bench clock
`timescale 1ns/1ps
module rts_far_end (
    output logic ext_osc_in,
    output logic rc_osc_in
);
    // ==============================
    // free-running sources
    initial begin
        ext_osc_in = 1'h0;
        forever #11.3 ext_osc_in = ~ext_osc_in;
    end
    initial begin
        rc_osc_in = 1'h0;
        forever #19.7 rc_osc_in = ~rc_osc_in;
    end
endmodule : rts_far_end

/* tb/rts_sequencer_test.sv */
// self-checking bench of the reset time-out sequencer
// assumes shortened stage counts and the far-end oscillator model
`timescale 1ns/1ps
module rts_sequencer_test
    import rts_pkg::*;
;
    logic clk;
    logic rst = 1'h1, ce = 1'h1, por_detect = 1'h0, supply_low = 1'h0, wake_req = 1'h0;
    logic master_clear_n = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic [31:0] q;
    logic wb_ack_o, core_reset, brownout_active, ext_osc_in, rc_osc_in;
    int fails = 0;
    int cmp_count = 0;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [3:0] s;
        logic [31:0] d;
        logic [31:0] e;
    } rts_row_s;
    localparam rts_row_s ROWS [9] = '{
        '{1'h0, 8'h00, 4'hF, 32'h0, 32'h0000000B}, '{1'h1, 8'h00, 4'hF, 32'hFFFFFFFF, 32'h0},
        '{1'h0, 8'h00, 4'hF, 32'h0, 32'h0000001F}, '{1'h1, 8'h00, 4'hE, 32'h0, 32'h0},
        '{1'h0, 8'h00, 4'hF, 32'h0, 32'h0000001F}, '{1'h1, 8'h08, 4'hF, 32'h0, 32'h0},
        '{1'h0, 8'h08, 4'hF, 32'h0, 32'h0}, '{1'h1, 8'h04, 4'hF, 32'h0, 32'h0},
        '{1'h0, 8'h04, 4'hF, 32'h0, 32'h00000041}};
    localparam logic [4:0] MODES [5] = '{5'h0B, 5'h07, 5'h1F, 5'h02, 5'h03};

    rts_far_end rts_far_end_inst (.ext_osc_in, .rc_osc_in);
    rts_sequencer #(
        .POWERUP_DELAY_TIMER_RC_TICKS(4),
        .OST_CYCLES(8),
        .PLL_LOCK_CYCLES(50),
        .BOR_MIN_CYCLES(3)
    ) rts_sequencer_inst (
        .clk, .rst, .ce, .por_detect, .supply_low, .master_clear_n, .ext_osc_in, .rc_osc_in,
        .wake_req, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .core_reset, .brownout_active
    );

    // ==============================
    // helpers
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        cmp_count++;
        if (v !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, v);
        end
    endtask : chk
    task automatic chk1(input string nm, input logic e, input logic v);
        chk(nm, {31'h0, e}, {31'h0, v});
    endtask : chk1
    task automatic give_verdict();
        if (fails == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
            input logic [31:0] d, output logic [31:0] rd);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        @(posedge clk);
        // no bound of its own here; if ack never comes, only the watchdog ends this wait
        while (wb_ack_o !== 1'h1)
            @(posedge clk);
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge clk);
        // ack and read data stand one cycle only
        chk1("ack", 1'h0, wb_ack_o);
        chk("dat", 32'h0, wb_dat_o);
    endtask : wb
    task automatic wait_low(input logic on_bor);
        int n;
        n = 0;
        while ((on_bor ? brownout_active : core_reset) !== 1'h0 && n < 300) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_low
    task automatic pulse(input logic wake);
        if (wake)
            wake_req <= 1'h1;
        else
            por_detect <= 1'h1;
        @(posedge clk);
        wake_req <= 1'h0;
        por_detect <= 1'h0;
    endtask : pulse
    task automatic power_on(input logic [4:0] c);
        logic [31:0] rd;
        logic [5:0] seen;
        logic [5:0] want;
        int n;
        want = RTS_ST_RUN | (c[0] ? RTS_ST_POWERUP_DELAY_TIMER : 6'h00) | (c[4] ? RTS_ST_PLL : 6'h00)
            | (c[3:2] != 2'h0 ? RTS_ST_OST : 6'h00);
        wb(1'h1, 8'h00, 4'hF, {27'h0, c}, rd);
        pulse(1'h0);
        repeat (4) @(posedge clk);
        chk1("core_reset", want != RTS_ST_RUN, core_reset);
        seen = 6'h00;
        n = 0;
        rd = 32'h40;
        while (rd[6] && n < 150) begin
            wb(1'h0, 8'h04, 4'hF, 32'h0, rd);
            seen = seen | rd[5:0];
            n++;
        end
        chk("stages", {26'h0, want}, {26'h0, seen});
    endtask : power_on

    // ==============================
    // clock, watchdog, tests
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        chk1("timeout", 1'h0, 1'h1);
        give_verdict();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        foreach (ROWS[i]) begin
            wb(ROWS[i].w, ROWS[i].a, ROWS[i].s, ROWS[i].d, q);
            if (!ROWS[i].w)
                chk("read", ROWS[i].e, q);
        end
        foreach (MODES[i])
            power_on(MODES[i]);
        supply_low <= 1'h1;
        repeat (2) @(posedge clk);
        supply_low <= 1'h0;
        repeat (6) @(posedge clk);
        chk1("brownout", 1'h0, brownout_active);
        supply_low <= 1'h1;
        repeat (10) @(posedge clk);
        chk1("brownout", 1'h1, brownout_active);
        supply_low <= 1'h0;
        wait_low(1'h1);
        repeat (15) @(posedge clk);
        chk1("core_reset", 1'h1, core_reset);
        supply_low <= 1'h1;
        repeat (8) @(posedge clk);
        chk1("brownout", 1'h1, brownout_active);
        supply_low <= 1'h0;
        wait_low(1'h1);
        repeat (25) @(posedge clk);
        chk1("core_reset", 1'h1, core_reset);
        wait_low(1'h0);
        chk1("core_reset", 1'h0, core_reset);
        wb(1'h1, 8'h00, 4'hF, 32'h01, q);
        supply_low <= 1'h1;
        repeat (10) @(posedge clk);
        chk1("brownout", 1'h0, brownout_active);
        supply_low <= 1'h0;
        // let the synchronised low level clear before brown-out is enabled again
        repeat (4) @(posedge clk);
        wb(1'h1, 8'h00, 4'hF, 32'h0B, q);
        pulse(1'h1);
        repeat (4) @(posedge clk);
        chk1("core_reset", 1'h1, core_reset);
        wait_low(1'h0);
        wb(1'h1, 8'h00, 4'hF, 32'h03, q);
        pulse(1'h1);
        repeat (4) @(posedge clk);
        chk1("core_reset", 1'h0, core_reset);
        master_clear_n <= 1'h0;
        pulse(1'h0);
        repeat (300) @(posedge clk);
        wb(1'h0, 8'h04, 4'hF, 32'h0, q);
        chk("status", 32'h00000160, q);
        master_clear_n <= 1'h1;
        repeat (5) @(posedge clk);
        chk1("core_reset", 1'h0, core_reset);
        rst <= 1'h1;
        @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        chk1("core_reset", 1'h1, core_reset);
        wb(1'h0, 8'h00, 4'hF, 32'h0, q);
        chk("ctrl", 32'h0000000B, q);
        give_verdict();
    end
endmodule : rts_sequencer_test

bind rts_sequencer rts_sequencer_properties #(.BOR_MIN_CYCLES(BOR_MIN_CYCLES))
    rts_sequencer_properties_inst (.clk, .rst, .ce, .supply_low, .master_clear_n, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .core_reset, .brownout_active);
